// ---- rtl/siodm_top.sv ----
`timescale 1ns/1ps
//Contract
// - Ten physical inputs are handled, each by its own logic.
// - Each input has a writable function code 0..99; input one resets to 1.
// - Input two's code resets to 42 and input three's to 0.
// - Each input's active level is set by its own setting.
// - An input is valid from its pin, its Modbus force bit or force register.
// - Active level is low, high, rising, falling or both edges.
// - Inputs one to eight are slow, nine and ten are fast.
// - Fast inputs need the opposite level held over 0.25 ms first.
// - A read-only status word shows input one at bit 0 to ten at bit 9.
// - Three outputs each follow one selected output function bit.
// - Each output has its own active level and a forced-output register.
// - Output one can carry encoder A or Z pulses and output two B pulses instead.
module siodm_top #(
   parameter int SLOW_CYC = siodm_pkg::SLOW_CYC,
   parameter int FAST_CYC = siodm_pkg::FAST_CYC
) (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic [9:0] physical_inputs,
   input wire logic [9:0] modbus_di_force,
   input wire logic [99:0] output_function_bit,
   input wire siodm_pkg::siodm_enc_sig_t enc_pulses,
   input wire siodm_pkg::siodm_par_req_t par_req,
   output logic [15:0] par_rdata,
   output logic [99:0] input_function_bit,
   output logic [9:0] input_valid_status,
   output logic [2:0] physical_outputs
);
   siodm_pkg::siodm_st_t q, d;
   logic [9:0] qual, rise, fall;
   logic [9:0] valid;

   ////////////////////////////////////////////////////////////////////////
   genvar gi;
   generate
      for (gi = 0; gi < siodm_pkg::NUM_DI; gi++) begin : g_di
         siodm_di_qual #(
            .CYC(gi < siodm_pkg::NUM_SLOW_DI ? SLOW_CYC : FAST_CYC)
         ) u_qual (
            .core_clk(core_clk),
            .nrst(nrst),
            .pin(physical_inputs[gi]),
            .qual_q(qual[gi]),
            .rise_q(rise[gi]),
            .fall_q(fall[gi])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      logic pin_ok;
      logic fb;
      logic act;
      logic [7:0] k;
      pin_ok = 1'b0;
      fb = 1'b0;
      act = 1'b0;
      k = '0;
      d = q;
      valid = '0;

      // Parameter writes; out-of-range codes are ignored except on output polarity and the two force registers, which take the low bits of any value
      if (par_req.wr) begin
         for (int i = 0; i < siodm_pkg::NUM_DI; i++) begin
            k = par_req.idx - siodm_pkg::IDX_DI_FSEL;
            if (k == 8'(i) && par_req.wdata <= siodm_pkg::FSEL_MAX) begin
               d.di_fsel[i] = par_req.wdata;
            end
            k = par_req.idx - siodm_pkg::IDX_DI_POL;
            if (k == 8'(i) && par_req.wdata <= 16'h0004) begin
               d.di_pol[i] = par_req.wdata[2:0];
            end
         end
         for (int j = 0; j < siodm_pkg::NUM_DO; j++) begin
            k = par_req.idx - siodm_pkg::IDX_DO_FSEL;
            if (k == 8'(j) && par_req.wdata <= siodm_pkg::FSEL_MAX) begin
               d.do_fsel[j] = par_req.wdata;
            end
            k = par_req.idx - siodm_pkg::IDX_DO_POL;
            if (k == 8'(j)) begin
               d.do_pol[j] = par_req.wdata[0];
            end
         end
         if (par_req.idx == siodm_pkg::IDX_DI_FORCE) begin
            d.di_force = par_req.wdata[9:0];
         end
         if (par_req.idx == siodm_pkg::IDX_DO_FORCE) begin
            d.do_force = par_req.wdata[2:0];
         end
         if (par_req.idx == siodm_pkg::IDX_ENC_SEL &&
             par_req.wdata <= 16'h0002) begin
            d.enc_sel = par_req.wdata[1:0];
         end
      end

      // Input qualification and forcing
      d.infunc = '0;
      for (int i = 0; i < siodm_pkg::NUM_DI; i++) begin
         unique case (siodm_pkg::siodm_pol_t'(q.di_pol[i]))
            siodm_pkg::POL_LOW: pin_ok = ~qual[i];
            siodm_pkg::POL_HIGH: pin_ok = qual[i];
            siodm_pkg::POL_RISE: pin_ok = rise[i];
            siodm_pkg::POL_FALL: pin_ok = fall[i];
            siodm_pkg::POL_BOTH: pin_ok = rise[i] | fall[i];
            default: pin_ok = 1'b0;
         endcase
         valid[i] = pin_ok | modbus_di_force[i] | q.di_force[i];
         // Code 0 means no function
         if (q.di_fsel[i] != 16'h0000 &&
             q.di_fsel[i] <= siodm_pkg::FSEL_MAX) begin
            d.infunc[q.di_fsel[i][6:0]] =
               d.infunc[q.di_fsel[i][6:0]] | valid[i];
         end
      end
      d.status = valid;

      // Output mapping; encoder routing takes precedence on 1 and 2
      for (int j = 0; j < siodm_pkg::NUM_DO; j++) begin
         fb = 1'b0;
         if (q.do_fsel[j] <= siodm_pkg::FSEL_MAX) begin
            fb = output_function_bit[q.do_fsel[j][6:0]];
         end
         act = fb | q.do_force[j];
         d.dout[j] = q.do_pol[j] ? ~act : act;
      end
      if (q.enc_sel == siodm_pkg::ENC_AB) begin
         d.dout[0] = enc_pulses.a;
         d.dout[1] = enc_pulses.b;
      end else if (q.enc_sel == siodm_pkg::ENC_Z) begin
         d.dout[0] = enc_pulses.z;
      end

      // Registered read-back
      d.rdata = '0;
      for (int i = 0; i < siodm_pkg::NUM_DI; i++) begin
         if (par_req.idx - siodm_pkg::IDX_DI_FSEL == 8'(i)) begin
            d.rdata = q.di_fsel[i];
         end
         if (par_req.idx - siodm_pkg::IDX_DI_POL == 8'(i)) begin
            d.rdata = {13'h0000, q.di_pol[i]};
         end
      end
      for (int j = 0; j < siodm_pkg::NUM_DO; j++) begin
         if (par_req.idx - siodm_pkg::IDX_DO_FSEL == 8'(j)) begin
            d.rdata = q.do_fsel[j];
         end
         if (par_req.idx - siodm_pkg::IDX_DO_POL == 8'(j)) begin
            d.rdata = {15'h0000, q.do_pol[j]};
         end
      end
      if (par_req.idx == siodm_pkg::IDX_DI_STATUS) begin
         d.rdata = {6'h00, q.status};
      end
      if (par_req.idx == siodm_pkg::IDX_DI_FORCE) begin
         d.rdata = {6'h00, q.di_force};
      end
      if (par_req.idx == siodm_pkg::IDX_DO_FORCE) begin
         d.rdata = {13'h0000, q.do_force};
      end
      if (par_req.idx == siodm_pkg::IDX_ENC_SEL) begin
         d.rdata = {14'h0000, q.enc_sel};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         q <= '0;
         for (int i = 0; i < siodm_pkg::NUM_DI; i++) begin
            q.di_fsel[i] <= siodm_pkg::DI_FSEL_RST;
            q.di_pol[i] <= siodm_pkg::DI_POL_RST;
         end
         q.di_fsel[0] <= siodm_pkg::DI1_FSEL_RST;
         q.di_fsel[1] <= siodm_pkg::DI2_FSEL_RST;
         for (int j = 0; j < siodm_pkg::NUM_DO; j++) begin
            q.do_fsel[j] <= siodm_pkg::DO_FSEL_RST;
         end
      end else begin
         q <= d;
      end
   end

   assign par_rdata = q.rdata;
   assign input_function_bit = q.infunc;
   assign input_valid_status = q.status;
   assign physical_outputs = q.dout;

   ////////////////////////////////////////////////////////////////////////
   sequence s_big_code_write;
      par_req.wr && par_req.idx == siodm_pkg::IDX_DI_FSEL &&
         par_req.wdata > siodm_pkg::FSEL_MAX;
   endsequence

   sequence s_status_read;
      par_req.idx == siodm_pkg::IDX_DI_STATUS;
   endsequence

   a_modbus_force: assert property (@(posedge core_clk)
      disable iff (!nrst) modbus_di_force != 10'h000 |=>
         (input_valid_status & $past(modbus_di_force)) ==
         $past(modbus_di_force))
      else $error("modbus force did not mark input valid");
   a_code_range: assert property (@(posedge core_clk)
      disable iff (!nrst) s_big_code_write |=> $stable(q.di_fsel[0]))
      else $error("out-of-range function code accepted");
   a_status_read: assert property (@(posedge core_clk)
      disable iff (!nrst)
      s_status_read |=> par_rdata == {6'h00, $past(input_valid_status)})
      else $error("status read-back mismatch");
   a_enc_route: assert property (@(posedge core_clk)
      disable iff (!nrst) q.enc_sel == siodm_pkg::ENC_AB |=>
         physical_outputs[0] == $past(enc_pulses.a) &&
         physical_outputs[1] == $past(enc_pulses.b))
      else $error("encoder pulses not routed");
   a_out_force: assert property (@(posedge core_clk)
      disable iff (!nrst) q.do_force[2] && !q.do_pol[2] |=>
         physical_outputs[2])
      else $error("forced output not driven");
   a_func_map: assert property (@(posedge core_clk)
      disable iff (!nrst)
      input_valid_status[0] && q.di_fsel[0] != 16'h0000 &&
         $stable(q.di_fsel[0]) |->
         input_function_bit[q.di_fsel[0][6:0]])
      else $error("valid input missing from function bits");
   a_low_level: assert property (@(posedge core_clk)
      disable iff (!nrst) q.di_pol[2] == siodm_pkg::POL_LOW && !qual[2] |=>
         input_valid_status[2])
      else $error("low-level input not valid");
endmodule

// ---- rtl/siodm_pkg.sv ----
package siodm_pkg;
   localparam int NUM_DI = 10;
   localparam int NUM_SLOW_DI = 8;
   localparam int NUM_DO = 3;
   localparam int NUM_FUNC = 100;
   localparam int CLK_MHZ = 40;

   // Qualification times, exceeded before a change is recognised
   localparam int SLOW_TIME_US = 3000;
   localparam int FAST_TIME_US = 250;
   localparam int SLOW_CYC = SLOW_TIME_US * CLK_MHZ;
   localparam int FAST_CYC = FAST_TIME_US * CLK_MHZ;

   // Parameter indices on the parameter port
   localparam logic [7:0] IDX_DI_FSEL = 8'h01;
   localparam logic [7:0] IDX_DI_STATUS = 8'h0d;
   localparam logic [7:0] IDX_DI_FORCE = 8'h0e;
   localparam logic [7:0] IDX_DI_POL = 8'h15;
   localparam logic [7:0] IDX_ENC_SEL = 8'h28;
   localparam logic [7:0] IDX_DO_FSEL = 8'h29;
   localparam logic [7:0] IDX_DO_POL = 8'h2c;
   localparam logic [7:0] IDX_DO_FORCE = 8'h32;

   localparam logic [15:0] FSEL_MAX = 16'h0063;
   localparam logic [15:0] DI1_FSEL_RST = 16'h0001;
   localparam logic [15:0] DI2_FSEL_RST = 16'h002a;
   localparam logic [15:0] DI_FSEL_RST = 16'h0000;
   localparam logic [15:0] DO_FSEL_RST = 16'h0000;

   typedef enum logic [2:0] {
      POL_LOW, POL_HIGH, POL_RISE, POL_FALL, POL_BOTH
   } siodm_pol_t;
   localparam siodm_pol_t DI_POL_RST = POL_HIGH;

   typedef enum logic [1:0] {
      ENC_OFF, ENC_AB, ENC_Z
   } siodm_enc_t;

   typedef struct packed {
      logic wr;
      logic [7:0] idx;
      logic [15:0] wdata;
   } siodm_par_req_t;

   typedef struct packed {
      logic a;
      logic b;
      logic z;
   } siodm_enc_sig_t;

   typedef struct packed {
      logic [2:0] sync;
      logic lvl;
      logic [17:0] cnt;
      logic qual;
      logic rise;
      logic fall;
   } siodm_qual_st_t;

   typedef struct packed {
      logic [NUM_DI-1:0][15:0] di_fsel;
      logic [NUM_DI-1:0][2:0] di_pol;
      logic [NUM_DI-1:0] di_force;
      logic [NUM_DO-1:0][15:0] do_fsel;
      logic [NUM_DO-1:0] do_pol;
      logic [NUM_DO-1:0] do_force;
      logic [1:0] enc_sel;
      logic [NUM_DI-1:0] status;
      logic [NUM_FUNC-1:0] infunc;
      logic [NUM_DO-1:0] dout;
      logic [15:0] rdata;
   } siodm_st_t;
endpackage

// ---- rtl/siodm_di_qual.sv ----
`timescale 1ns/1ps
module siodm_di_qual #(
   parameter int CYC = 1
) (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic pin,
   output logic qual_q,
   output logic rise_q,
   output logic fall_q
);
   siodm_pkg::siodm_qual_st_t q, d;
   logic [17:0] lim;
   assign lim = 18'(CYC);

   always_comb begin
      d = q;
      d.sync = {q.sync[1:0], pin};
      d.rise = 1'b0;
      d.fall = 1'b0;
      // Change counts once second and third stage agree
      if (q.sync[1] == q.sync[2] && q.sync[2] != q.lvl) begin
         d.lvl = q.sync[2];
         d.cnt = '0;
         if (q.cnt > lim) begin
            d.qual = q.sync[2];
            d.rise = q.sync[2] & ~q.qual;
            d.fall = ~q.sync[2] & q.qual;
         end
      end else begin
         if (q.cnt <= lim) begin
            d.cnt = q.cnt + 18'h00001;
         end
         // Long-held level adopted without an edge, so later edges count
         if (q.cnt > lim && q.qual != q.lvl) begin
            d.qual = q.lvl;
         end
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign qual_q = q.qual;
   assign rise_q = q.rise;
   assign fall_q = q.fall;

   a_qual_settle: assert property (@(posedge core_clk)
      disable iff (!nrst) $changed(q.qual) |-> $past(q.cnt) > lim)
      else $error("qualified level changed before persistence time");
   a_edge_pulse: assert property (@(posedge core_clk)
      disable iff (!nrst)
      (q.rise || q.fall) |=> !(q.rise || q.fall) && $stable(q.qual))
      else $error("edge pulse longer than one cycle");
endmodule

// ---- dv/siodm_field.sv ----
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////
// Switches drive the inputs, lamps load the outputs
module siodm_field (
   input wire logic core_clk,
   input wire logic [9:0] sw_cmd,
   input wire logic [2:0] physical_outputs,
   output logic [9:0] physical_inputs,
   output logic [2:0] lamp_on
);
   // Contacts move one edge late, like a real switch behind wiring
   always_ff @(posedge core_clk) begin
      physical_inputs <= sw_cmd;
   end
   assign lamp_on = physical_outputs;
endmodule

// ---- dv/servo_digital_io_mapper_tb_top.sv ----
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin \
   err_total++; $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module servo_digital_io_mapper_tb_top;
   logic core_clk = 1'b0;
   logic nrst = 1'b0;
   logic [9:0] sw_cmd = 10'h000;
   logic [9:0] physical_inputs;
   logic [9:0] modbus_di_force = 10'h000;
   logic [99:0] output_function_bit = '0;
   siodm_pkg::siodm_enc_sig_t enc_pulses = '0;
   siodm_pkg::siodm_par_req_t par_req = '0;
   logic [15:0] par_rdata;
   logic [99:0] input_function_bit;
   logic [9:0] input_valid_status;
   logic [2:0] physical_outputs;
   logic [2:0] lamp_on;
   int err_total = 0;
   int num_checks = 0;

   always #12.5 core_clk = ~core_clk;

   // Short qualification counts keep the run brief
   siodm_top #(.SLOW_CYC(20), .FAST_CYC(5)) dut_u (
      .core_clk(core_clk),
      .nrst(nrst),
      .physical_inputs(physical_inputs),
      .modbus_di_force(modbus_di_force),
      .output_function_bit(output_function_bit),
      .enc_pulses(enc_pulses),
      .par_req(par_req),
      .par_rdata(par_rdata),
      .input_function_bit(input_function_bit),
      .input_valid_status(input_valid_status),
      .physical_outputs(physical_outputs)
   );
   siodm_field field_u (
      .core_clk(core_clk),
      .sw_cmd(sw_cmd),
      .physical_outputs(physical_outputs),
      .physical_inputs(physical_inputs),
      .lamp_on(lamp_on)
   );

   ////////////////////////////////////////////////////////////////////
   task automatic finish_test();
      if (err_total == 0 && num_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   task automatic par_wr(input logic [7:0] i, input logic [15:0] d);
      @(posedge core_clk);
      par_req <= '{wr: 1'b1, idx: i, wdata: d};
      @(posedge core_clk);
      par_req.wr <= 1'b0;
   endtask
   task automatic par_rd(input logic [7:0] i, output logic [15:0] d);
      @(posedge core_clk);
      par_req <= '{wr: 1'b0, idx: i, wdata: 16'h0000};
      cyc(2);
      #1 d = par_rdata;
   endtask
   task automatic wait_st(input int i, input logic v, input int n);
      int k;
      k = 0;
      while (input_valid_status[i] !== v && k < n) begin
         @(posedge core_clk);
         #1 k++;
      end
      `CHK(input_valid_status[i], v)
      if (err_total != 0) finish_test();
   endtask

   ////////////////////////////////////////////////////////////////////
   task automatic t_regs();
      logic [15:0] d;
      par_rd(8'h01, d);
      `CHK(d, 16'h0001)
      par_rd(8'h02, d);
      `CHK(d, 16'h002a)
      par_rd(8'h03, d);
      `CHK(d, 16'h0000)
      par_rd(8'h7f, d);
      `CHK(d, 16'h0000)
      par_wr(8'h01, 16'h0064);
      par_rd(8'h01, d);
      `CHK(d, 16'h0001)
      par_wr(8'h01, 16'h0063);
      par_rd(8'h01, d);
      `CHK(d, 16'h0063)
      par_wr(8'h01, 16'h0001);
      par_wr(8'h0d, 16'h03ff);
      par_rd(8'h0d, d);
      `CHK(d, 16'h0000)
   endtask
   task automatic t_force();
      logic [15:0] d;
      par_wr(8'h0e, 16'h0001);
      cyc(2);
      #1;
      `CHK(input_valid_status, 10'h001)
      `CHK(input_function_bit[1], 1'b1)
      par_rd(8'h0d, d);
      `CHK(d, 16'h0001)
      par_wr(8'h0e, 16'h0000);
      modbus_di_force <= 10'h002;
      cyc(3);
      #1;
      `CHK(input_valid_status, 10'h002)
      `CHK(input_function_bit[42], 1'b1)
      @(posedge core_clk) modbus_di_force <= 10'h000;
      cyc(3);
   endtask
   // Short low: slow input drops and must wait to rise again, fast input must not
   task automatic t_speed();
      @(posedge core_clk) sw_cmd <= 10'h101;
      wait_st(0, 1'b1, 12);
      wait_st(8, 1'b1, 12);
      cyc(30);
      sw_cmd <= 10'h000;
      cyc(10);
      sw_cmd <= 10'h101;
      cyc(12);
      #1;
      `CHK(input_valid_status[0], 1'b0)
      `CHK(input_valid_status[8], 1'b1)
      cyc(20);
      #1;
      `CHK(input_valid_status[0], 1'b1)
      @(posedge core_clk) sw_cmd <= 10'h000;
      cyc(30);
   endtask
   task automatic t_modes();
      logic [3:0] exp [5] = '{4'h4, 4'h8, 4'h2, 4'h1, 4'h3};
      int nr;
      int nf;
      logic eh;
      logic el;
      for (int m = 0; m < 5; m++) begin
         par_wr(8'h17, 16'(m));
         cyc(30);
         sw_cmd <= 10'h004;
         nr = 0;
         for (int k = 0; k < 30; k++) begin
            @(posedge core_clk);
            #1 nr += input_valid_status[2];
         end
         eh = input_valid_status[2];
         @(posedge core_clk) sw_cmd <= 10'h000;
         nf = 0;
         for (int k = 0; k < 30; k++) begin
            @(posedge core_clk);
            #1 nf += input_valid_status[2];
         end
         el = input_valid_status[2];
         `CHK({eh, el, nr == 1, nf == 1}, exp[m])
      end
      par_wr(8'h17, 16'h0001);
   endtask
   task automatic t_out();
      par_wr(8'h29, 16'h0007);
      output_function_bit[7] <= 1'b1;
      cyc(3);
      #1;
      `CHK(lamp_on, 3'b001)
      par_wr(8'h2c, 16'h0001);
      cyc(2);
      #1;
      `CHK(lamp_on, 3'b000)
      par_wr(8'h32, 16'h0006);
      cyc(2);
      #1;
      `CHK(lamp_on, 3'b110)
      par_wr(8'h28, 16'h0001);
      enc_pulses <= '{a: 1'b1, b: 1'b0, z: 1'b1};
      cyc(3);
      #1;
      `CHK(lamp_on[1:0], 2'b01)
      par_wr(8'h28, 16'h0002);
      enc_pulses <= '{a: 1'b0, b: 1'b1, z: 1'b1};
      cyc(2);
      #1;
      `CHK(lamp_on[1:0], 2'b11)
   endtask

   ////////////////////////////////////////////////////////////////////
   initial begin
      cyc(12);
      nrst <= 1'b1;
      // Let every qualifier see a long low first
      cyc(30);
      t_regs();
      t_force();
      t_speed();
      t_modes();
      t_out();
      finish_test();
   end
endmodule
